// ### design/mcc_pkg.sv
package mcc_pkg;
  // ---------------------------------------------------------------
  // register map (word offsets on wishbone)
  // ---------------------------------------------------------------
  localparam logic [3:0] MCC_ADR_STATUS = 4'h0;
  localparam logic [3:0] MCC_ADR_TONE   = 4'h4;
  localparam logic [3:0] MCC_ADR_POWER  = 4'h8;
  localparam logic [7:0] MCC_STATUS_RST = 8'h00;
  localparam logic [7:0] MCC_TONE_RST   = 8'h00;
  localparam int         MCC_BIT_CLKOUT = 7;
  localparam int         MCC_BIT_SLOW   = 4;
  localparam int         MCC_BIT_TIE    = 1;
  localparam int         MCC_BIT_FLAG   = 0;
  // ---------------------------------------------------------------
  // counts in oscillator cycles
  // ---------------------------------------------------------------
  localparam logic [17:0] MCC_TB0 = 18'd16000;
  localparam logic [17:0] MCC_TB1 = 18'd32000;
  localparam logic [17:0] MCC_TB2 = 18'd80000;
  localparam logic [17:0] MCC_TB3 = 18'd200000;
  // half periods of the tone at 8 MHz: 2 kHz, 1 kHz, 500 Hz
  localparam logic [13:0] MCC_TONE1 = 14'd2000;
  localparam logic [13:0] MCC_TONE2 = 14'd4000;
  localparam logic [13:0] MCC_TONE3 = 14'd8000;

  typedef enum logic [1:0] {MCC_RUN, MCC_WAIT, MCC_AHALT, MCC_HALT} mcc_pwr_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [1:0]  tone_sel;
    logic [1:0]  tb_cur;
    logic [17:0] tb_cnt;
    logic [3:0]  pre_cnt;
    logic        core_clk;
    logic [13:0] tone_cnt;
    logic        tone;
    mcc_pwr_t    pwr;
    logic [31:0] rdata;
    logic        ack;
  } mcc_state_t;
endpackage : mcc_pkg

// ### design/mcc_main_clock_ctrl.sv
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module mcc_main_clock_ctrl
  import mcc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        halt_exec_i,
  input  wire logic        wait_exec_i,
  input  wire logic        halt_wake_i,
  output logic             core_clk_o,
  output logic             clock_out_pin_o,
  output logic             clock_out_pin_oe_o,
  output logic             tone_pin_o,
  output logic             tone_pin_oe_o,
  output logic             tick_irq_o,
  output logic             active_halt_o,
  output logic             full_halt_o
);
  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [17:0] tb_len(input logic [1:0] s);
    case (s)
      2'b00:   tb_len = MCC_TB0;
      2'b01:   tb_len = MCC_TB1;
      2'b10:   tb_len = MCC_TB2;
      default: tb_len = MCC_TB3;
    endcase
  endfunction : tb_len

  function automatic logic [13:0] tone_len(input logic [1:0] s);
    case (s)
      2'b01:   tone_len = MCC_TONE1;
      2'b10:   tone_len = MCC_TONE2;
      default: tone_len = MCC_TONE3;
    endcase
  endfunction : tone_len

  mcc_state_t s;
  mcc_state_t next_s;
  logic       wr;
  logic       rd;
  logic       tb_end;
  logic       frozen;
  logic       tick;
  logic [3:0] pre_top;

  assign wr      = cyc_i && stb_i && we_i && !s.ack && sel_i[0];
  assign rd      = cyc_i && stb_i && !we_i && !s.ack;
  assign frozen  = (s.pwr == MCC_AHALT) || (s.pwr == MCC_HALT);
  assign tb_end  = s.tb_cnt == tb_len(s.tb_cur) - 18'd1;
  assign tick    = tb_end && (s.pwr != MCC_HALT);
  // divide by 2^(ratio+1): toggle every 2^ratio cycles
  assign pre_top = 4'((5'd1 << s.status[6:5]) - 5'd1);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s     = s;
    next_s.ack = cyc_i && stb_i && !s.ack;
    // full halt stops the time base entirely
    if (s.pwr != MCC_HALT) begin
      next_s.tb_cnt = tb_end ? 18'd0 : s.tb_cnt + 18'd1;
      if (tb_end) begin
        next_s.tb_cur = s.status[3:2];
      end
    end
    // core clock keeps running in every mode but full halt
    if (s.pwr != MCC_HALT) begin
      if (!s.status[MCC_BIT_SLOW]) begin
        next_s.pre_cnt  = 4'h0;
        next_s.core_clk = !s.core_clk;
      end else if (s.pre_cnt >= pre_top) begin
        next_s.pre_cnt  = 4'h0;
        next_s.core_clk = !s.core_clk;
      end else begin
        next_s.pre_cnt = s.pre_cnt + 4'h1;
      end
    end
    // beeper also runs in active-halt
    if (s.tone_sel == 2'b00 || s.pwr == MCC_HALT) begin
      next_s.tone_cnt = 14'h0;
      next_s.tone     = 1'b0;
    end else if (s.tone_cnt >= tone_len(s.tone_sel) - 14'd1) begin
      next_s.tone_cnt = 14'h0;
      next_s.tone     = !s.tone;
    end else begin
      next_s.tone_cnt = s.tone_cnt + 14'h1;
    end
    // registers: frozen in active-halt and full halt
    if (!frozen && wr && adr_i == MCC_ADR_STATUS) begin
      next_s.status[7:1] = dat_i[7:1];
    end
    if (!frozen && wr && adr_i == MCC_ADR_TONE) begin
      next_s.tone_sel = dat_i[1:0];
    end
    next_s.rdata = 32'h0;
    if (rd) begin
      case (adr_i)
        MCC_ADR_STATUS: next_s.rdata = {24'h0, s.status};
        MCC_ADR_TONE:   next_s.rdata = {30'h0, s.tone_sel};
        MCC_ADR_POWER:  next_s.rdata = {30'h0, s.pwr};
        default:        next_s.rdata = 32'h0;
      endcase
    end
    // set wins over the read clear
    if (rd && adr_i == MCC_ADR_STATUS && !frozen) begin
      next_s.status[MCC_BIT_FLAG] = 1'b0;
    end
    if (tick) begin
      next_s.status[MCC_BIT_FLAG] = 1'b1;
    end
    // power state; wait leaves all logic untouched
    case (s.pwr)
      MCC_RUN: begin
        if (halt_exec_i) begin
          next_s.pwr = s.status[MCC_BIT_TIE] ? MCC_AHALT : MCC_HALT;
        end else if (wait_exec_i) begin
          next_s.pwr = MCC_WAIT;
        end
      end
      MCC_WAIT: begin
        if ((tick && s.status[MCC_BIT_TIE]) || halt_wake_i) begin
          next_s.pwr = MCC_RUN;
        end
      end
      MCC_AHALT: begin
        if ((tick && s.status[MCC_BIT_TIE]) || halt_wake_i) begin
          next_s.pwr = MCC_RUN;
        end
      end
      MCC_HALT: begin
        if (halt_wake_i) begin
          next_s.pwr = MCC_RUN;
        end
      end
      default: next_s.pwr = MCC_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s        <= '0;
      s.status <= MCC_STATUS_RST;
      s.pwr    <= MCC_RUN;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dat_o              = s.rdata;
  assign ack_o              = s.ack;
  assign core_clk_o         = s.core_clk;
  // pin is released to general i/o when clock-out is off
  assign clock_out_pin_oe_o = s.status[MCC_BIT_CLKOUT];
  assign clock_out_pin_o    = s.core_clk && s.status[MCC_BIT_CLKOUT]
                              && (s.pwr != MCC_AHALT);
  assign tone_pin_oe_o      = s.tone_sel != 2'b00;
  assign tone_pin_o         = s.tone;
  assign tick_irq_o         = s.status[MCC_BIT_FLAG] && s.status[MCC_BIT_TIE];
  assign active_halt_o      = s.pwr == MCC_AHALT;
  assign full_halt_o        = s.pwr == MCC_HALT;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
      tick_irq_o |-> (s.status[0] && s.status[1]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without flag and enable");
  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
      tick |=> s.status[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("tick did not set flag");
  property p_read_clear;
    @(posedge clk_i) disable iff (rst_i)
      (rd && adr_i == MCC_ADR_STATUS && !frozen && !tick) |=> !s.status[0];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read kept flag");
  property p_ahalt_pin;
    @(posedge clk_i) disable iff (rst_i)
      active_halt_o |-> !clock_out_pin_o;
  endproperty
  a_ahalt_pin: assert property (p_ahalt_pin) else $error("clock out in active halt");
  property p_halt_freeze;
    @(posedge clk_i) disable iff (rst_i)
      (full_halt_o && !halt_wake_i) |=> $stable(s.tb_cnt);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("counter ran in halt");
  property p_no_wake;
    @(posedge clk_i) disable iff (rst_i)
      (full_halt_o && !halt_wake_i) |=> full_halt_o;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("left halt without wake");
  property p_enter;
    @(posedge clk_i) disable iff (rst_i)
      (s.pwr == MCC_RUN && halt_exec_i && s.status[1]) |=> active_halt_o;
  endproperty
  a_enter: assert property (p_enter) else $error("no active halt entry");
  property p_tb_hold;
    @(posedge clk_i) disable iff (rst_i)
      !tb_end |=> $stable(s.tb_cur);
  endproperty
  a_tb_hold: assert property (p_tb_hold) else $error("time base changed mid period");
  property p_normal;
    @(posedge clk_i) disable iff (rst_i)
      (!s.status[4] && !full_halt_o) |=> (core_clk_o != $past(core_clk_o));
  endproperty
  a_normal: assert property (p_normal) else $error("core clock not toggling");
  // ---------------------------------------------------------------
  // time base checks
  // ---------------------------------------------------------------
  property p_tick_end;
    @(posedge clk_i) disable iff (rst_i)
      tick |=> (s.tb_cnt == 18'd0);
  endproperty
  a_tick_end: assert property (p_tick_end) else $error("divider not restarted");
  property p_tb_count;
    @(posedge clk_i) disable iff (rst_i)
      (!full_halt_o && !tb_end) |=> (s.tb_cnt == $past(s.tb_cnt) + 18'd1);
  endproperty
  a_tb_count: assert property (p_tb_count) else $error("divider skipped a cycle");
  property p_tb_latch;
    @(posedge clk_i) disable iff (rst_i)
      tick |=> (s.tb_cur == $past(s.status[3:2]));
  endproperty
  a_tb_latch: assert property (p_tb_latch) else $error("base not taken at period end");
  property p_tb_range;
    @(posedge clk_i) disable iff (rst_i)
      s.tb_cnt < tb_len(s.tb_cur);
  endproperty
  a_tb_range: assert property (p_tb_range) else $error("divider past period");
  property p_tick_halt;
    @(posedge clk_i) disable iff (rst_i)
      full_halt_o |-> !tick;
  endproperty
  a_tick_halt: assert property (p_tick_halt) else $error("tick during full halt");
  property p_flag_hold;
    @(posedge clk_i) disable iff (rst_i)
      (!tick && !(rd && adr_i == MCC_ADR_STATUS && !frozen)) |=> $stable(s.status[0]);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag moved without cause");
  // ---------------------------------------------------------------
  // clock and tone checks
  // ---------------------------------------------------------------
  property p_clkout_follow;
    @(posedge clk_i) disable iff (rst_i)
      (clock_out_pin_oe_o && !active_halt_o) |-> (clock_out_pin_o == core_clk_o);
  endproperty
  a_clkout_follow: assert property (p_clkout_follow) else $error("clock out wrong");
  property p_clkout_off;
    @(posedge clk_i) disable iff (rst_i)
      !clock_out_pin_oe_o |-> !clock_out_pin_o;
  endproperty
  a_clkout_off: assert property (p_clkout_off) else $error("clock out while released");
  property p_slow_hold;
    @(posedge clk_i) disable iff (rst_i)
      (s.status[4] && !full_halt_o && s.pre_cnt < pre_top) |=> $stable(core_clk_o);
  endproperty
  a_slow_hold: assert property (p_slow_hold) else $error("slow clock toggled early");
  property p_halt_clk;
    @(posedge clk_i) disable iff (rst_i)
      full_halt_o |=> $stable(core_clk_o);
  endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("core clock ran in halt");
  property p_tone_off;
    @(posedge clk_i) disable iff (rst_i)
      (s.tone_sel == 2'b00) |=> !tone_pin_o;
  endproperty
  a_tone_off: assert property (p_tone_off) else $error("tone while off");
  property p_tone_hold;
    @(posedge clk_i) disable iff (rst_i)
      (s.tone_sel != 2'b00 && !full_halt_o && s.tone_cnt < tone_len(s.tone_sel) - 14'd1)
      |=> $stable(tone_pin_o);
  endproperty
  a_tone_hold: assert property (p_tone_hold) else $error("tone toggled early");
  // ---------------------------------------------------------------
  // power checks
  // ---------------------------------------------------------------
  property p_frozen_regs;
    @(posedge clk_i) disable iff (rst_i)
      frozen |=> ($stable(s.status[7:1]) && $stable(s.tone_sel));
  endproperty
  a_frozen_regs: assert property (p_frozen_regs) else $error("register moved while frozen");
  property p_ahalt_wake;
    @(posedge clk_i) disable iff (rst_i)
      (active_halt_o && tick && s.status[1]) |=> !active_halt_o;
  endproperty
  a_ahalt_wake: assert property (p_ahalt_wake) else $error("tick did not wake");
  property p_wait_wake;
    @(posedge clk_i) disable iff (rst_i)
      (s.pwr == MCC_WAIT && tick && s.status[1]) |=> (s.pwr == MCC_RUN);
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("tick did not end wait");
  property p_wait_only_run;
    @(posedge clk_i) disable iff (rst_i)
      (s.pwr == MCC_WAIT) |=> (s.pwr == MCC_WAIT || s.pwr == MCC_RUN);
  endproperty
  a_wait_only_run: assert property (p_wait_only_run) else $error("wait left wrongly");
  property p_enter_full;
    @(posedge clk_i) disable iff (rst_i)
      (s.pwr == MCC_RUN && halt_exec_i && !s.status[1]) |=> full_halt_o;
  endproperty
  a_enter_full: assert property (p_enter_full) else $error("no full halt entry");
  // ---------------------------------------------------------------
  // bus checks
  // ---------------------------------------------------------------
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_resp;
    @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not answered");
  property p_write_status;
    @(posedge clk_i) disable iff (rst_i)
      (!frozen && wr && adr_i == MCC_ADR_STATUS) |=> (s.status[7:1] == $past(dat_i[7:1]));
  endproperty
  a_write_status: assert property (p_write_status) else $error("write not applied");
  property p_read_data;
    @(posedge clk_i) disable iff (rst_i)
      (rd && adr_i == MCC_ADR_STATUS) |=> (dat_o[7:0] == $past(s.status));
  endproperty
  a_read_data: assert property (p_read_data) else $error("status read data wrong");
  property p_rd_zero;
    @(posedge clk_i) disable iff (rst_i)
      (rd && adr_i != MCC_ADR_STATUS && adr_i != MCC_ADR_TONE && adr_i != MCC_ADR_POWER)
      |=> (dat_o == 32'h0);
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
  c_wait:  cover property (@(posedge clk_i) s.pwr == MCC_WAIT ##1 s.pwr == MCC_RUN);
  c_fhalt: cover property (@(posedge clk_i) full_halt_o ##1 !full_halt_o);
  c_tick:  cover property (@(posedge clk_i) tick);
  c_ahalt: cover property (@(posedge clk_i) active_halt_o ##1 !active_halt_o);
  c_tone:  cover property (@(posedge clk_i) $rose(tone_pin_o));
endmodule : mcc_main_clock_ctrl

// ### tb/mcc_core_model.sv
`timescale 1ns/1ps
module mcc_core_model (
  input  wire logic clk_i,
  output logic      halt_exec_o,
  output logic      wait_exec_o,
  output logic      halt_wake_o
);
  initial begin
    halt_exec_o = 1'b0;
    wait_exec_o = 1'b0;
    halt_wake_o = 1'b0;
  end
  // kind 0 halt, 1 wait, 2 wake; one-cycle pulse as the core issues it
  task automatic pulse(input logic [1:0] kind);
    halt_exec_o <= (kind == 2'd0);
    wait_exec_o <= (kind == 2'd1);
    halt_wake_o <= (kind == 2'd2);
    @(posedge clk_i);
    halt_exec_o <= 1'b0;
    wait_exec_o <= 1'b0;
    halt_wake_o <= 1'b0;
  endtask : pulse
endmodule : mcc_core_model

// ### tb/test_main_clock_ctrl_rtc.sv
`timescale 1ns/1ps
module test_main_clock_ctrl_rtc
  import mcc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic [7:0]  q;
  logic        ack, cclk, co, co_oe, tone, tone_oe, irq, ahalt, fhalt, hx, wx, wk;
  int          num_errors = 0;
  int          n_tests = 0;
  int          k;
  int          n;
  time         t0, t1;

  initial forever #20 clk = ~clk;

  mcc_main_clock_ctrl i_dut (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .halt_exec_i(hx),
    .wait_exec_i(wx), .halt_wake_i(wk), .core_clk_o(cclk), .clock_out_pin_o(co),
    .clock_out_pin_oe_o(co_oe), .tone_pin_o(tone), .tone_pin_oe_o(tone_oe),
    .tick_irq_o(irq), .active_halt_o(ahalt), .full_halt_o(fhalt)
  );
  mcc_core_model i_core (.clk_i(clk), .halt_exec_o(hx), .wait_exec_o(wx), .halt_wake_o(wk));

  task automatic stop_test;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %0h got %0h", nm, exp, got);
    end
  endtask : chk

  task automatic guard(input logic ok);
    if (!ok) begin
      num_errors++;
      stop_test();
    end
  endtask : guard

  // whole-register access only: a bit set/clear would read and lose a pending flag
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= {24'h0, d};
    k = 0;
    // ack and read data are looked at mid-cycle, where they have settled
    do begin
      @(negedge clk);
      k++;
    end while (ack !== 1'b1 && k < 9);
    guard(ack === 1'b1);
    q = rdat[7:0];
    @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  // cycles between two changes of the core clock or the tone pin
  task automatic half(input logic pick, output int cnt);
    logic v;
    k = 0;
    @(negedge clk);
    v = pick ? tone : cclk;
    while ((pick ? tone : cclk) === v && k < 20000) begin
      @(negedge clk);
      k++;
    end
    v = pick ? tone : cclk;
    cnt = 0;
    while ((pick ? tone : cclk) === v && cnt < 20000) begin
      @(negedge clk);
      cnt++;
      if (!pick) chk("clkout", co, cclk);
    end
    guard(cnt < 20000);
  endtask : half

  task automatic wait_irq(output time t);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (irq !== 1'b1 && k < 40000);
    guard(irq === 1'b1);
    t = $time;
  endtask : wait_irq

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    wb(1'b0, MCC_ADR_STATUS, 8'h00);
    chk("status", q, MCC_STATUS_RST);
    wb(1'b0, MCC_ADR_TONE, 8'h00);
    chk("tone", q, MCC_TONE_RST);
    wb(1'b0, 4'hC, 8'h00);
    chk("unmapped", q, 8'h00);
  endtask : t_reset

  task automatic t_prescale;
    wb(1'b1, MCC_ADR_STATUS, 8'h80);
    chk("clkout_oe", co_oe, 1'b1);
    half(1'b0, n);
    chk("normal_half", n, 1);
    for (int r = 0; r < 4; r++) begin
      wb(1'b1, MCC_ADR_STATUS, {1'b1, 2'(r), 5'h10});
      half(1'b0, n);
      chk("slow_half", n, 1 << r);
    end
  endtask : t_prescale

  task automatic t_tone;
    wb(1'b1, MCC_ADR_TONE, 8'h01);
    chk("tone_oe", tone_oe, 1'b1);
    half(1'b1, n);
    chk("tone_half", n, MCC_TONE1);
    wb(1'b1, MCC_ADR_TONE, 8'h00);
    chk("tone_off", tone_oe, 1'b0);
  endtask : t_tone

  // base change lands mid-period, then the part sleeps through the longer one
  task automatic t_tick;
    wb(1'b1, MCC_ADR_STATUS, 8'h02);
    wait_irq(t0);
    wb(1'b0, MCC_ADR_STATUS, 8'h00);
    chk("flag_set", q, 8'h03);
    wb(1'b1, MCC_ADR_STATUS, 8'h06);
    wb(1'b0, MCC_ADR_STATUS, 8'h00);
    chk("flag_clr", q, 8'h06);
    chk("irq_clr", irq, 1'b0);
    wait_irq(t1);
    chk("old_base", 32'((t1 - t0) / 40), MCC_TB0);
    wb(1'b0, MCC_ADR_STATUS, 8'h00);
    wb(1'b1, MCC_ADR_STATUS, 8'h86);
    i_core.pulse(2'd0);
    @(posedge clk);
    chk("ahalt", {fhalt, ahalt}, 2'b01);
    repeat (40) begin
      @(posedge clk);
      chk("clkout_hold", co, 1'b0);
    end
    wb(1'b1, MCC_ADR_STATUS, 8'h00);
    wb(1'b0, MCC_ADR_STATUS, 8'h00);
    chk("frozen", q, 8'h86);
    wait_irq(t0);
    chk("new_base", 32'((t0 - t1) / 40), MCC_TB1);
    repeat (2) @(posedge clk);
    chk("woken", ahalt, 1'b0);
  endtask : t_tick

  task automatic t_halts;
    wb(1'b0, MCC_ADR_STATUS, 8'h00);
    chk("flag_again", q, 8'h87);
    wb(1'b1, MCC_ADR_STATUS, 8'h00);
    i_core.pulse(2'd0);
    @(posedge clk);
    chk("fhalt", {fhalt, ahalt}, 2'b10);
    wb(1'b0, MCC_ADR_POWER, 8'h00);
    chk("halt_state", q, 8'h03);
    i_core.pulse(2'd2);
    @(posedge clk);
    chk("halt_exit", fhalt, 1'b0);
    i_core.pulse(2'd1);
    wb(1'b0, MCC_ADR_POWER, 8'h00);
    chk("wait_state", q, 8'h01);
    i_core.pulse(2'd2);
  endtask : t_halts

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_prescale();
    t_tone();
    t_tick();
    t_halts();
    stop_test();
  end
endmodule : test_main_clock_ctrl_rtc
